// file: shared/cct_pkg.sv
// Purpose: Shared constants and types for the card cycle timing block.
// Assumes: Counts are whole host clock cycles.
// Notes: Register map, config fields, phase counts and states live here.
package cct_pkg;
    localparam int CNT_W = 8;
    localparam int ADDR_W = 26;
    localparam int REG_AW = 8;
    localparam int DATA_W = 32;

    // Register offsets; window configs take one word each.
    localparam logic [7:0] OFF_CFG_BASE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h40;

    // Window config fields.
    localparam int CFG_W = 5;
    localparam int CFG_WS_LSB = 0;
    localparam int CFG_ZWS_BIT = 2;
    localparam int CFG_TS_LSB = 3;
    localparam logic [4:0] CFG_RST = 5'h08;

    // Status fields.
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_LEN_LSB = 8;

    // Address setup counts and the extra margin added before the strobe.
    localparam logic [7:0] SU_IO = 8'h03;
    localparam logic [7:0] SU_MEM0 = 8'h02;
    localparam logic [7:0] SU_MEM1 = 8'h04;
    localparam logic [7:0] SU_EXTRA = 8'h02;
    // Address hold counts and the extra margin after the strobe.
    localparam logic [7:0] HD_IO = 8'h02;
    localparam logic [7:0] HD_MEM0 = 8'h02;
    localparam logic [7:0] HD_MEM1 = 8'h03;
    localparam logic [7:0] HD_EXTRA = 8'h01;
    // Command active counts, 8-bit cycles.
    localparam logic [7:0] C8_NOWS = 8'h13;
    localparam logic [7:0] C8_WS = 8'h17;
    localparam logic [7:0] C8_ZWS = 8'h07;
    // Command active counts, 16-bit cycles.
    localparam logic [7:0] C16_IO = 8'h07;
    localparam logic [7:0] C16_IO_WS = 8'h0b;
    localparam logic [7:0] C16_M00 = 8'h09;
    localparam logic [7:0] C16_M01 = 8'h0d;
    localparam logic [7:0] C16_M10 = 8'h11;
    localparam logic [7:0] C16_M11 = 8'h17;
    localparam logic [7:0] C16_ZWS = 8'h05;

    // Strobe bit positions.
    localparam int STB_OE = 0;
    localparam int STB_WE = 1;
    localparam int STB_IORD = 2;
    localparam int STB_IOWR = 3;

    typedef enum logic [3:0] {
        CCT_IDLE = 4'h1,
        CCT_SETUP = 4'h2,
        CCT_CMD = 4'h4,
        CCT_HOLD = 4'h8
    } cct_state_e;
endpackage

// file: shared/cct_lut_if.sv
// Purpose: Carries a latched window setting to the count lookup and back.
// Assumes: Lookup is purely combinational.
// Notes: The sequencer drives the settings, the lookup the counts.
`timescale 1ns/1ps
interface cct_lut_if;
    logic [1:0] ws;
    logic zws;
    logic is_io;
    logic is_16;
    logic [cct_pkg::CNT_W-1:0] setup_cyc;
    logic [cct_pkg::CNT_W-1:0] cmd_cyc;
    logic [cct_pkg::CNT_W-1:0] hold_cyc;
    modport req (output ws, zws, is_io, is_16,
                 input setup_cyc, cmd_cyc, hold_cyc);
    modport lut (input ws, zws, is_io, is_16,
                 output setup_cyc, cmd_cyc, hold_cyc);
endinterface

// file: design/cct_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Reset value is the idle level, high.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module cct_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk, // Host clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [W-1:0] d, // Asynchronous input.
    output logic [W-1:0] q // Synchronised output.
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cct_sync_s;

    cct_sync_s s;
    cct_sync_s next_s;

    // The first stage feeds only the second stage.
    always_comb begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    // Idle level after reset so no false wait is seen.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end

    assign q = s.s2;
endmodule

// file: design/cct_lut.sv
// Purpose: Maps a window setting and cycle type to phase lengths.
// Assumes: Timing set selection does not change the counts.
// Notes: Setup and hold include the extra margin clocks.
`timescale 1ns/1ps
module cct_lut (
    cct_lut_if.lut lif // Setting in, counts out.
);
    // Setup and hold depend on cycle type and the upper wait bit.
    always_comb begin
        if (lif.is_io) begin
            lif.setup_cyc = cct_pkg::SU_IO + cct_pkg::SU_EXTRA;
            lif.hold_cyc = cct_pkg::HD_IO + cct_pkg::HD_EXTRA;
        end else if (lif.ws[1]) begin
            lif.setup_cyc = cct_pkg::SU_MEM1 + cct_pkg::SU_EXTRA;
            lif.hold_cyc = cct_pkg::HD_MEM1 + cct_pkg::HD_EXTRA;
        end else begin
            lif.setup_cyc = cct_pkg::SU_MEM0 + cct_pkg::SU_EXTRA;
            lif.hold_cyc = cct_pkg::HD_MEM0 + cct_pkg::HD_EXTRA;
        end
    end

    // Command active time; any wait state beats zero wait.
    always_comb begin
        if (!lif.is_16) begin
            if (lif.is_io ? lif.ws[0] : (lif.ws != 2'h0)) begin
                lif.cmd_cyc = cct_pkg::C8_WS;
            end else if (lif.zws) begin
                lif.cmd_cyc = cct_pkg::C8_ZWS;
            end else begin
                lif.cmd_cyc = cct_pkg::C8_NOWS;
            end
        end else if (lif.is_io) begin
            // No zero-wait I/O on 16-bit cycles.
            lif.cmd_cyc = lif.ws[0] ? cct_pkg::C16_IO_WS : cct_pkg::C16_IO;
        end else begin
            case (lif.ws)
                2'h0: begin
                    lif.cmd_cyc = lif.zws ? cct_pkg::C16_ZWS
                                          : cct_pkg::C16_M00;
                end
                2'h1: lif.cmd_cyc = cct_pkg::C16_M01;
                2'h2: lif.cmd_cyc = cct_pkg::C16_M10;
                default: lif.cmd_cyc = cct_pkg::C16_M11;
            endcase
        end
    end
endmodule

// file: design/cct_card16.sv
// Purpose: Card cycle sequencer: address setup, strobe, address hold.
// Assumes: Card wait pin is asynchronous and active low.
// Notes: Window settings are written over a plain register port.
`timescale 1ns/1ps
module cct_card16 #(
    parameter int NWIN = 4,
    parameter int WIN_W = 2
) (
    input wire logic sys_clk, // Host clock, 25 MHz.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [7:0] reg_addr, // Register byte address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Write strobe.
    input wire logic reg_rd, // Read strobe.
    output logic [31:0] reg_rdata, // Read data, cycle after strobe.
    input wire logic cyc_req, // Start a card cycle.
    input wire logic [WIN_W-1:0] cyc_win, // Window being accessed.
    input wire logic cyc_io, // I/O cycle when high.
    input wire logic cyc_16, // 16-bit access when high.
    input wire logic cyc_write, // Write when high.
    input wire logic cyc_attr, // Attribute space when high.
    input wire logic [25:0] cyc_addr, // Card address.
    output logic cyc_ready, // Sequencer idle.
    output logic cyc_done, // Pulse when hold has ended.
    output logic [25:0] card_addr, // Card address pins.
    output logic card_addr_oe, // Address driven.
    output logic card_reg_n, // Attribute select, active low.
    output logic card_oe_n, // Memory read strobe.
    output logic card_we_n, // Memory write strobe.
    output logic card_iord_n, // I/O read strobe.
    output logic card_iowr_n, // I/O write strobe.
    input wire logic card_wait_n // Card wait, active low.
);
    localparam int CW = cct_pkg::CNT_W;
    localparam int FW = cct_pkg::CFG_W;
    localparam logic [7:0] CFG_SPAN = 8'(4 * NWIN);
    localparam logic [CW-1:0] ONE = CW'(1);

    typedef struct packed {
        cct_pkg::cct_state_e st;
        logic [CW-1:0] cnt;
        logic [NWIN-1:0][FW-1:0] cfg;
        logic [FW-1:0] lat;
        logic io;
        logic b16;
        logic wr;
        logic attr;
        logic [cct_pkg::ADDR_W-1:0] addr;
        logic [3:0] strb;
        logic done;
        logic [CW-1:0] last_len;
        logic [31:0] rdata;
    } cct_state_s;

    localparam cct_state_s RST_S = '{
        st: cct_pkg::CCT_IDLE,
        cfg: {NWIN{cct_pkg::CFG_RST}},
        default: '0
    };

    cct_state_s s;
    cct_state_s next_s;
    logic [0:0] wait_sync;
    logic wait_act;
    logic cfg_hit;
    logic [7:0] cfg_off;
    logic [WIN_W-1:0] widx;

    cct_lut_if lt();

    // The card wait pin is asynchronous to the host clock.
    cct_sync #(
        .W(1)
    ) u_wait_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d(card_wait_n),
        .q(wait_sync)
    );

    assign wait_act = ~wait_sync[0];

    // Counts always come from the latched setting, never the live one.
    assign lt.ws = s.lat[cct_pkg::CFG_WS_LSB +: 2];
    assign lt.zws = s.lat[cct_pkg::CFG_ZWS_BIT];
    assign lt.is_io = s.io;
    assign lt.is_16 = s.b16;

    cct_lut u_lut (
        .lif(lt)
    );

    // Window config decode; only aligned words inside the span hit.
    assign cfg_off = reg_addr - cct_pkg::OFF_CFG_BASE;
    assign cfg_hit = (reg_addr[1:0] == 2'h0)
                   && (reg_addr >= cct_pkg::OFF_CFG_BASE)
                   && (cfg_off < CFG_SPAN);
    assign widx = cfg_off[WIN_W+1:2];

    // Sequencer and register file, one next-state process.
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        next_s.rdata = '0;
        if (reg_rd) begin
            if (cfg_hit) begin
                next_s.rdata[FW-1:0] = s.cfg[widx];
            end else if (reg_addr == cct_pkg::OFF_STATUS) begin
                next_s.rdata[cct_pkg::STAT_BUSY_BIT] =
                    (s.st != cct_pkg::CCT_IDLE);
                next_s.rdata[cct_pkg::STAT_LEN_LSB +: CW] = s.last_len;
            end
        end
        // Writes land in the table; a running cycle keeps its copy.
        if (reg_wr && cfg_hit) begin
            next_s.cfg[widx] = reg_wdata[FW-1:0];
        end
        case (s.st)
            cct_pkg::CCT_IDLE: begin
                if (cyc_req) begin
                    next_s.lat = s.cfg[cyc_win];
                    next_s.io = cyc_io;
                    next_s.b16 = cyc_16;
                    next_s.wr = cyc_write;
                    next_s.attr = cyc_attr;
                    next_s.addr = cyc_addr;
                    next_s.cnt = '0;
                    next_s.st = cct_pkg::CCT_SETUP;
                end
            end
            cct_pkg::CCT_SETUP: begin
                // Address drives for the full setup count first.
                if (s.cnt == lt.setup_cyc - ONE) begin
                    next_s.cnt = '0;
                    next_s.st = cct_pkg::CCT_CMD;
                end else begin
                    next_s.cnt = s.cnt + ONE;
                end
            end
            cct_pkg::CCT_CMD: begin
                // Minimum time first, then wait must be seen released.
                if (s.cnt >= lt.cmd_cyc - ONE && !wait_act) begin
                    // Saturate so a very long wait never reads back as 0.
                    next_s.last_len = (s.cnt == '1) ? s.cnt : s.cnt + ONE;
                    next_s.cnt = '0;
                    next_s.st = cct_pkg::CCT_HOLD;
                end else if (s.cnt != '1) begin
                    next_s.cnt = s.cnt + ONE;
                end
            end
            cct_pkg::CCT_HOLD: begin
                if (s.cnt == lt.hold_cyc - ONE) begin
                    next_s.cnt = '0;
                    next_s.done = 1'b1;
                    next_s.st = cct_pkg::CCT_IDLE;
                end else begin
                    next_s.cnt = s.cnt + ONE;
                end
            end
            default: begin
                next_s.st = cct_pkg::CCT_IDLE;
            end
        endcase
        // Strobes follow the command phase exactly.
        next_s.strb = '0;
        if (next_s.st == cct_pkg::CCT_CMD) begin
            if (next_s.io) begin
                next_s.strb[cct_pkg::STB_IORD] = ~next_s.wr;
                next_s.strb[cct_pkg::STB_IOWR] = next_s.wr;
            end else begin
                next_s.strb[cct_pkg::STB_OE] = ~next_s.wr;
                next_s.strb[cct_pkg::STB_WE] = next_s.wr;
            end
        end
    end

    // All state is in one record.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= RST_S;
        end else begin
            s <= next_s;
        end
    end

    // Card pins are plain decodes of registered state.
    assign card_addr = s.addr;
    assign card_addr_oe = (s.st != cct_pkg::CCT_IDLE);
    assign card_reg_n = ~(s.attr && card_addr_oe);
    assign card_oe_n = ~s.strb[cct_pkg::STB_OE];
    assign card_we_n = ~s.strb[cct_pkg::STB_WE];
    assign card_iord_n = ~s.strb[cct_pkg::STB_IORD];
    assign card_iowr_n = ~s.strb[cct_pkg::STB_IOWR];
    assign cyc_ready = (s.st == cct_pkg::CCT_IDLE);
    assign cyc_done = s.done;
    assign reg_rdata = s.rdata;

    // Cycles spent in the current phase, counted apart from the design.
    logic [CW-1:0] ph_len;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ph_len <= ONE;
        end else if (next_s.st != s.st) begin
            ph_len <= ONE;
        end else if (ph_len != '1) begin
            ph_len <= ph_len + ONE;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!arst_n);

    a_setup_len: assert property (
        (s.st == cct_pkg::CCT_SETUP) ##1 (s.st == cct_pkg::CCT_CMD)
        |-> ($past(ph_len) == $past(lt.setup_cyc)) && card_addr_oe)
    else $error("address setup phase has the wrong length");

    a_setup_table: assert property (
        (s.st == cct_pkg::CCT_SETUP)
        |-> lt.setup_cyc == (s.io ? 8'h05 : (lt.ws[1] ? 8'h06 : 8'h04)))
    else $error("setup count does not match cycle type");

    a_cmd_len8: assert property (
        (s.st == cct_pkg::CCT_CMD) && !s.b16 && lt.ws == 2'h0 && lt.zws
        |-> lt.cmd_cyc == 8'h07)
    else $error("8-bit zero-wait strobe count wrong");

    a_cmd_len16: assert property (
        (s.st == cct_pkg::CCT_CMD) && s.b16 && !s.io && lt.ws == 2'h2
        |-> lt.cmd_cyc == 8'h11)
    else $error("16-bit memory strobe count wrong");

    a_cmd_min: assert property (
        (s.st == cct_pkg::CCT_CMD) ##1 (s.st == cct_pkg::CCT_HOLD)
        |-> $past(ph_len) >= $past(lt.cmd_cyc)
            && $past(ph_len) == s.last_len)
    else $error("strobe released before its minimum time");

    a_wait_ext: assert property (
        (s.st == cct_pkg::CCT_CMD) && wait_act
        |=> (s.st == cct_pkg::CCT_CMD) && $stable(s.strb))
    else $error("strobe ended while card wait active");

    a_hold_len: assert property (
        (s.st == cct_pkg::CCT_HOLD) ##1 (s.st == cct_pkg::CCT_IDLE)
        |-> $past(ph_len) == $past(lt.hold_cyc) && cyc_done)
    else $error("address hold phase has the wrong length");

    a_hold_table: assert property (
        (s.st == cct_pkg::CCT_HOLD) && !s.io && lt.ws[1]
        |-> lt.hold_cyc == 8'h04)
    else $error("memory hold count wrong for upper wait bit");

    a_addr_stable: assert property (
        (s.st != cct_pkg::CCT_IDLE) ##1 (s.st != cct_pkg::CCT_IDLE)
        |-> $stable(card_addr) && $stable(card_reg_n))
    else $error("card address moved during a cycle");

    a_cfg_frozen: assert property (
        (s.st != cct_pkg::CCT_IDLE) ##1 (s.st != cct_pkg::CCT_IDLE)
        |-> $stable(s.lat) && $stable(s.io) && $stable(s.b16))
    else $error("latched window setting changed mid cycle");

    a_strobe_phase: assert property (
        $fell(card_oe_n) || $fell(card_iord_n)
        |-> $past(card_addr_oe, 4) && s.st == cct_pkg::CCT_CMD)
    else $error("strobe asserted without prior address setup");
endmodule

// file: testbench/cct_card_model.sv
// Purpose: Far-side model of a 16-bit card that may stretch each strobe.
// Assumes: The wait line has a pull-up, so a released wait reads high.
// Notes: wait_len sets how many strobe clocks wait is held low.
`timescale 1ns/1ps
module cct_card_model (
    input wire logic sys_clk, // Host clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic [3:0] strobe_n, // The four command strobes, active low.
    input wire logic [7:0] wait_len, // Strobe clocks with wait held low.
    output logic card_wait_n // Card wait, active low.
);
    logic [7:0] cnt;

    // Wait is pulled low from the first strobe clock; the pull-up wins
    // between strobes, so a stale low never leaks into the next cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 8'h00;
            card_wait_n <= 1'b1;
        end else if (strobe_n != 4'hf) begin
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            card_wait_n <= ~(cnt < wait_len);
        end else begin
            cnt <= 8'h00;
            card_wait_n <= 1'b1;
        end
    end
endmodule

// file: testbench/tb_card16_cycle_timing.sv
// Purpose: Self-checking bench for the card cycle timing block.
// Assumes: Window words at 4*i, status at 8'h40, as the package gives.
// Notes: Phase lengths are counted on falling edges, where outputs settle.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
 $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_card16_cycle_timing;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic cyc_req = 1'b0;
    logic [1:0] cyc_win = 2'h0;
    logic cyc_io = 1'b0;
    logic cyc_16 = 1'b0;
    logic cyc_write = 1'b0;
    logic cyc_attr = 1'b0;
    logic [25:0] cyc_addr = 26'h0;
    logic cyc_ready, cyc_done, card_addr_oe, card_reg_n, card_wait_n;
    logic card_oe_n, card_we_n, card_iord_n, card_iowr_n;
    logic [25:0] card_addr;
    logic [3:0] stb_n;
    logic [7:0] wait_len = 8'h00;
    int fails = 0;
    int n_compared = 0;
    integer seed = 32'h05849ebc;

    // Free-running host clock, 40 ns period.
    always #20 sys_clk = ~sys_clk;
    assign stb_n = {card_iowr_n, card_iord_n, card_we_n, card_oe_n};

    cct_card16 #(.NWIN(4), .WIN_W(2)) uut (.sys_clk(sys_clk),
        .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cyc_req(cyc_req), .cyc_win(cyc_win), .cyc_io(cyc_io),
        .cyc_16(cyc_16), .cyc_write(cyc_write), .cyc_attr(cyc_attr),
        .cyc_addr(cyc_addr), .cyc_ready(cyc_ready), .cyc_done(cyc_done),
        .card_addr(card_addr), .card_addr_oe(card_addr_oe),
        .card_reg_n(card_reg_n), .card_oe_n(card_oe_n),
        .card_we_n(card_we_n), .card_iord_n(card_iord_n),
        .card_iowr_n(card_iowr_n), .card_wait_n(card_wait_n));

    cct_card_model card (.sys_clk(sys_clk), .arst_n(arst_n),
        .strobe_n(stb_n), .wait_len(wait_len), .card_wait_n(card_wait_n));

    // Expected phase lengths, margin clocks included.
    function automatic logic [7:0] exp_s(logic io, logic [1:0] ws);
        return io ? 8'h05 : (ws[1] ? 8'h06 : 8'h04);
    endfunction
    function automatic logic [7:0] exp_h(logic io, logic [1:0] ws);
        return (!io && ws[1]) ? 8'h04 : 8'h03;
    endfunction
    function automatic logic [7:0] exp_c(logic io, logic b16,
        logic [1:0] ws, logic zws);
        if (!b16 && (io ? ws[0] : (ws != 2'b00)))
            return 8'h17;
        if (!b16)
            return zws ? 8'h07 : 8'h13;
        if (io)
            return ws[0] ? 8'h0b : 8'h07;
        case (ws)
            2'b00: return zws ? 8'h05 : 8'h09;
            2'b01: return 8'h0d;
            2'b10: return 8'h11;
            default: return 8'h17;
        endcase
    endfunction

    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask

    // One card cycle; poke tries a second request and a config rewrite
    // mid-cycle, both of which must leave the running cycle untouched.
    task automatic run_cycle(input logic io, b16, wr, attr,
        input logic [1:0] ws, input logic zws, input logic [7:0] wl,
        input logic poke);
        logic [31:0] r;
        logic [25:0] a;
        logic [7:0] wa, ec;
        logic [3:0] sv;
        int s, c, h, n;
        r = $random(seed);
        a = r[27:2];
        wa = {4'h0, r[1:0], 2'b00};
        s = 0;
        c = 0;
        h = 0;
        n = 0;
        ec = exp_c(io, b16, ws, zws);
        sv = io ? (wr ? 4'b1000 : 4'b0100) : (wr ? 4'b0010 : 4'b0001);
        reg_write(wa, {27'h0, 2'b01, zws, ws});
        reg_read(wa, r);
        `CHK(r, {27'h0, 2'b01, zws, ws})
        @(posedge sys_clk);
        wait_len <= wl;
        cyc_req <= 1'b1;
        cyc_win <= wa[3:2];
        cyc_io <= io;
        cyc_16 <= b16;
        cyc_write <= wr;
        cyc_attr <= attr;
        cyc_addr <= a;
        @(posedge sys_clk);
        cyc_req <= 1'b0;
        fork
            while (cyc_done !== 1'b1 && n < 300) begin
                @(negedge sys_clk);
                n++;
                if (stb_n !== 4'hf) begin
                    c++;
                    `CHK(~stb_n, sv)
                end else if (card_addr_oe === 1'b1) begin
                    if (c > 0) h++;
                    else s++;
                end
                if (card_addr_oe === 1'b1) begin
                    `CHK({cyc_ready, card_addr}, {1'b0, a})
                    `CHK(card_reg_n, ~attr)
                end
            end
            if (poke) begin
                repeat (3) @(posedge sys_clk);
                cyc_req <= 1'b1;
                cyc_addr <= ~a;
                reg_addr <= wa;
                reg_wdata <= {27'h0, 2'b01, ~zws, ~ws};
                reg_wr <= 1'b1;
                @(posedge sys_clk);
                cyc_req <= 1'b0;
                reg_wr <= 1'b0;
                reg_addr <= 8'h40;
                reg_rd <= 1'b1;
                @(posedge sys_clk);
                reg_rd <= 1'b0;
                @(negedge sys_clk);
                `CHK(reg_rdata[0], 1'b1)
            end
        join
        `CHK({cyc_ready, card_addr_oe, stb_n}, 6'h2f)
        `CHK(s, int'(exp_s(io, ws)))
        `CHK(h, int'(exp_h(io, ws)))
        if (int'(wl) + 6 <= int'(ec)) begin
            `CHK(c, int'(ec))
        end else begin
            `CHK(c >= int'(ec) && c > int'(wl) && c <= int'(wl) + 6, 1'b1)
        end
        reg_read(8'h40, r);
        `CHK(r, {16'h0, c[7:0], 8'h00})
    endtask

    // Watchdog: the whole run needs well under 10000 clocks.
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        end_of_test();
    end

    initial begin
        logic [31:0] rd;
        logic [4:0] k;
        int i;
        @(negedge sys_clk);
        `CHK({cyc_ready, card_addr_oe, card_reg_n, stb_n}, 7'h5f)
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            reg_read(8'(i * 4), rd);
            `CHK(rd, 32'h00000008)
        end
        reg_write(8'h01, 32'h0000001f);
        reg_read(8'h00, rd);
        `CHK(rd, 32'h00000008)
        reg_read(8'h44, rd);
        `CHK(rd, 32'h00000000)
        // Every width, type, wait setting and zero-wait choice.
        for (i = 0; i < 32; i++) begin
            k = i[4:0];
            rd = $random(seed);
            run_cycle(k[0], k[1], rd[0], rd[1], k[3:2], k[4],
                {5'h0, rd[4:2]}, i % 7 == 3);
        end
        // A card that holds wait well past the minimum strobe.
        run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 2'b00, 1'b0, 8'h1e, 1'b1);
        run_cycle(1'b0, 1'b1, 1'b1, 1'b0, 2'b00, 1'b1, 8'h0c, 1'b0);
        end_of_test();
    end
endmodule
